// File: rtl/sadcrs_seq.sv
`timescale 1ns/1ps
`include "sadcrs_map.svh"
module sadcrs_seq (
   // clock and reset
   input wire logic I_CLOCK,
   input wire logic I_RST_N,
   // serial link from host
   input wire logic I_BIT_CLOCK,
   input wire logic I_SELECT_SHUTDOWN_N,
   // converter sample (straight binary code of the analog input)
   input wire logic [11:0] I_SAMPLE_CODE,
   // serial link to host
   output logic O_DOUT,
   output logic O_DOUT_OE,
   // converter status
   output logic O_SAMPLING,
   output logic O_CONV_ACTIVE,
   output logic O_POWERED
);
   logic rst_s1_r;
   logic rst_n_r;
   logic clk_d_r;
   sadcrs_pkg::sadcrs_state_e state_r;
   sadcrs_pkg::sadcrs_state_e state_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   sadcrs_pkg::sadcrs_word_t shreg_r;
   sadcrs_pkg::sadcrs_word_t shreg_nxt;
   sadcrs_pkg::sadcrs_word_t held_r;
   sadcrs_pkg::sadcrs_word_t held_nxt;
   sadcrs_pkg::sadcrs_pin_s pin_r;
   sadcrs_pkg::sadcrs_pin_s pin_nxt;
   logic smpl_r;
   logic conv_r;
   logic pwr_r;

   // reset release through two flip-flops
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // shift toward the msb end, a zero enters at the lsb
   function automatic sadcrs_pkg::sadcrs_word_t shl1(input sadcrs_pkg::sadcrs_word_t w);
      return {w[10:0], 1'b0};
   endfunction : shl1

   // shift toward the lsb end, a zero enters at the msb
   function automatic sadcrs_pkg::sadcrs_word_t shr1(input sadcrs_pkg::sadcrs_word_t w);
      return {1'b0, w[11:1]};
   endfunction : shr1

   // bit-clock edge detection; all link steps except the select abort happen on its falling edges
   // the bit clock is a level sampled here, so each of its phases must
   // last at least one system clock or a fall can be missed
   // the delayed copy resets high, the parked level of the bit clock,
   // so that leaving reset with the bit clock parked high never looks like a falling edge
   wire selected = ~I_SELECT_SHUTDOWN_N;
   wire fall_edge = clk_d_r & ~I_BIT_CLOCK;
   wire last_cnt = (cnt_r == (`SADCRS_CONV_CYCLES - 4'h1));

   // sequence decode, one step per falling bit-clock edge
   // fall 1 opens the sample window, fall 2 captures the code and turns
   // the driver on with the null bit, falls 3 to 14 give the word msb
   // first, falls 15 to 25 replay bits 1 to 11, then zeroes follow
   // select high overrides every step, so an abort always wins
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      shreg_nxt = shreg_r;
      held_nxt = held_r;
      pin_nxt = pin_r;
      if (!selected) begin
         state_nxt = sadcrs_pkg::SADCRS_SHUT;
         cnt_nxt = 4'h0;
         pin_nxt.oe = 1'b0;
         pin_nxt.data = `SADCRS_NULL_BIT;
      end else if (fall_edge) begin
         case (state_r)
            sadcrs_pkg::SADCRS_SHUT: begin
               // first falling edge opens the sample window
               state_nxt = sadcrs_pkg::SADCRS_SAMPLE;
               cnt_nxt = 4'h1;
            end
            sadcrs_pkg::SADCRS_SAMPLE: begin
               if (cnt_r == (`SADCRS_EN_EDGE - 4'h1)) begin
                  // sample held, driver on with the null bit
                  held_nxt = I_SAMPLE_CODE;
                  shreg_nxt = I_SAMPLE_CODE;
                  pin_nxt.oe = 1'b1;
                  pin_nxt.data = `SADCRS_NULL_BIT;
                  state_nxt = sadcrs_pkg::SADCRS_NULL;
                  cnt_nxt = 4'h0;
               end else begin
                  cnt_nxt = cnt_r + 4'h1;
               end
            end
            sadcrs_pkg::SADCRS_NULL: begin
               // MSB first during conversion
               pin_nxt.data = shreg_r[11];
               shreg_nxt = shl1(shreg_r);
               state_nxt = sadcrs_pkg::SADCRS_MSB;
               cnt_nxt = 4'h1;
            end
            sadcrs_pkg::SADCRS_MSB: begin
               if (last_cnt) begin
                  // bit 0 is the last msb-first bit; converter off after it
                  // the replay then starts at bit 1, bit 0 being shared
                  pin_nxt.data = shreg_r[11];
                  shreg_nxt = shr1(held_r);
                  state_nxt = sadcrs_pkg::SADCRS_LSB;
                  cnt_nxt = 4'h1;
               end else begin
                  pin_nxt.data = shreg_r[11];
                  shreg_nxt = shl1(shreg_r);
                  cnt_nxt = cnt_r + 4'h1;
               end
            end
            sadcrs_pkg::SADCRS_LSB: begin
               // lsb-first replay of the held word
               pin_nxt.data = shreg_r[0];
               shreg_nxt = shr1(shreg_r);
               if (last_cnt) begin
                  state_nxt = sadcrs_pkg::SADCRS_ZERO;
               end
               cnt_nxt = cnt_r + 4'h1;
            end
            sadcrs_pkg::SADCRS_ZERO: begin
               // zeroes for as long as the host keeps clocking
               pin_nxt.data = 1'b0;
            end
            default: begin
               state_nxt = sadcrs_pkg::SADCRS_SHUT;
            end
         endcase
      end
   end

   // state registers
   // the edge detector copy resets to the parked high level of the bit clock
   always_ff @(posedge I_CLOCK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         clk_d_r <= 1'b1;
         state_r <= sadcrs_pkg::SADCRS_SHUT;
         cnt_r <= 4'h0;
         shreg_r <= 12'h000;
         held_r <= 12'h000;
         pin_r <= '0;
      end else begin
         clk_d_r <= I_BIT_CLOCK;
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shreg_r <= shreg_nxt;
         held_r <= held_nxt;
         pin_r <= pin_nxt;
      end
   end

   // status flags from the next state so they line up with the pin
   // conversion covers the null bit and msb-first bits 11 to 1; power is
   // held from the sample window until the last msb-first bit leaves
   wire conv_nxt = (state_nxt == sadcrs_pkg::SADCRS_NULL) |
                   (state_nxt == sadcrs_pkg::SADCRS_MSB);
   always_ff @(posedge I_CLOCK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         smpl_r <= 1'b0;
         conv_r <= 1'b0;
         pwr_r <= 1'b0;
      end else begin
         smpl_r <= (state_nxt == sadcrs_pkg::SADCRS_SAMPLE);
         conv_r <= conv_nxt;
         pwr_r <= conv_nxt | (state_nxt == sadcrs_pkg::SADCRS_SAMPLE);
      end
   end

   // outputs straight from flip-flops
   // enable low means the pin floats; data is parked low meanwhile
   assign O_DOUT = pin_r.data;
   assign O_DOUT_OE = pin_r.oe;
   assign O_SAMPLING = smpl_r;
   assign O_CONV_ACTIVE = conv_r;
   assign O_POWERED = pwr_r;
endmodule : sadcrs_seq

// File: rtl/sadcrs_map.svh
`ifndef SADCRS_MAP_SVH
`define SADCRS_MAP_SVH
// result width and conversion length in bit-clock cycles
`define SADCRS_DATA_BITS 12
`define SADCRS_CONV_CYCLES 4'hC
// falling bit-clock edges after select falls before the output is enabled
`define SADCRS_EN_EDGE 4'h2
// sample window in bit-clock edges (falling edge 1 to falling edge 2 after select)
`define SADCRS_SMPL_EDGES 4'h2
// idle level of the serial output while driven with no data
`define SADCRS_NULL_BIT 1'b0
`endif

// File: rtl/sadcrs_pkg.sv
package sadcrs_pkg;
   typedef enum logic [2:0] {
      SADCRS_SHUT = 3'b000,
      SADCRS_SAMPLE = 3'b001,
      SADCRS_NULL = 3'b010,
      SADCRS_MSB = 3'b011,
      SADCRS_LSB = 3'b100,
      SADCRS_ZERO = 3'b101
   } sadcrs_state_e;
   typedef logic [11:0] sadcrs_word_t;
   // serial output pin as value plus enable
   typedef struct packed {
      logic data;
      logic oe;
   } sadcrs_pin_s;
endpackage : sadcrs_pkg

// File: verif/sadcrs_seq_assertions.sv
`timescale 1ns/1ps
module sadcrs_seq_assertions (
   // clock, reset and host lines
   input wire logic I_CLOCK,
   input wire logic I_RST_N,
   input wire logic I_BIT_CLOCK,
   input wire logic I_SELECT_SHUTDOWN_N,
   // device outputs
   input wire logic O_DOUT,
   input wire logic O_DOUT_OE,
   input wire logic O_SAMPLING,
   input wire logic O_CONV_ACTIVE,
   input wire logic O_POWERED
);
   logic bc_q;
   logic [3:0] cnt_r;
   wire fall = bc_q & ~I_BIT_CLOCK;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (!I_RST_N);
   // count bit-clock falls while converting
   always_ff @(posedge I_CLOCK) begin
      bc_q <= I_BIT_CLOCK;
      cnt_r <= O_CONV_ACTIVE ? cnt_r + 4'(fall) : 4'h0;
   end
   hiz_sel_a: assert property (I_SELECT_SHUTDOWN_N |=> !O_DOUT_OE)
      else $error("oe on");
   shut_mode_a: assert property (I_SELECT_SHUTDOWN_N [*2] |-> !O_POWERED && !O_SAMPLING)
      else $error("awake");
   seq_end_a: assert property ($rose(I_SELECT_SHUTDOWN_N) |=> !O_DOUT && !O_CONV_ACTIVE)
      else $error("no end");
   dout_edge_a: assert property ($changed(O_DOUT) |-> $past(fall) || $past(I_SELECT_SHUTDOWN_N))
      else $error("dout moved");
   oe_null_a: assert property ($rose(O_DOUT_OE) |-> $past(fall) && !O_DOUT && O_CONV_ACTIVE)
      else $error("oe start");
   smpl_open_a: assert property ($rose(O_SAMPLING) |-> $past(fall) && !O_DOUT_OE)
      else $error("smpl open");
   smpl_close_a: assert property ($fell(O_SAMPLING) && !$past(I_SELECT_SHUTDOWN_N) |-> O_DOUT_OE)
      else $error("smpl close");
   conv_len_a: assert property ($fell(O_CONV_ACTIVE) && !$past(I_SELECT_SHUTDOWN_N)
      |-> cnt_r == 4'hC && !O_POWERED)
      else $error("conv len");
   cover property ($fell(O_CONV_ACTIVE) && !O_POWERED);
   cover property ($rose(O_DOUT_OE));
   cover property ($rose(I_SELECT_SHUTDOWN_N) && O_CONV_ACTIVE);
endmodule : sadcrs_seq_assertions
bind sadcrs_seq sadcrs_seq_assertions u_chk (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
   .I_BIT_CLOCK(I_BIT_CLOCK), .I_SELECT_SHUTDOWN_N(I_SELECT_SHUTDOWN_N), .O_DOUT(O_DOUT),
   .O_DOUT_OE(O_DOUT_OE), .O_SAMPLING(O_SAMPLING), .O_CONV_ACTIVE(O_CONV_ACTIVE),
   .O_POWERED(O_POWERED));

// File: verif/sadcrs_host.sv
`timescale 1ns/1ps
module sadcrs_host (
   input wire logic clk,
   input wire logic dout,
   input wire logic oe,
   output logic bclk,
   output logic sel_n,
   output logic [31:0] got
);
   // idle: deselected, bit clock parked high
   initial begin
      bclk = 1'b1;
      sel_n = 1'b1;
      got = '0;
   end
   // one exchange of n falls, half period h cycles
   task automatic xfer(input int n, input int h);
      repeat (2) @(negedge clk);
      sel_n = 1'b0;
      for (int k = 1; k <= n; k++) begin
         repeat (h) @(negedge clk);
         bclk = 1'b0;
         repeat (h) @(negedge clk);
         bclk = 1'b1;
         got[k] = oe ? dout : ~got[k-1];
      end
      repeat (h) @(negedge clk);
      sel_n = 1'b1;
   endtask : xfer
endmodule : sadcrs_host

// File: verif/sadcrs_seq_tb.sv
`timescale 1ns/1ps
module sadcrs_seq_tb;
   logic clk, rst_n, bclk, sel_n, dout, oe;
   logic [11:0] code;
   logic [31:0] got;
   int err_total, checks_done;
   sadcrs_seq dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_BIT_CLOCK(bclk),
      .I_SELECT_SHUTDOWN_N(sel_n), .I_SAMPLE_CODE(code), .O_DOUT(dout), .O_DOUT_OE(oe),
      .O_SAMPLING(), .O_CONV_ACTIVE(), .O_POWERED());
   sadcrs_host h (.clk(clk), .dout(dout), .oe(oe), .bclk(bclk), .sel_n(sel_n), .got(got));
   // null bit, msb-first word, lsb-first replay, then zeroes
   function automatic logic exp_bit(input logic [11:0] c, input int k);
      if (k == 2 || k > 25) return 1'b0;
      return k < 15 ? c[14-k] : c[k-14];
   endfunction : exp_bit
   task automatic chk(input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk
   task automatic end_sim;
      $display("errors=%0d checks=%0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard
   initial begin
      #80000;
      err_total++;
      end_sim();
   end
   // abort once, then corner and random codes at several bit rates
   initial begin
      rst_n = 1'b0;
      code = 12'h000;
      err_total = 0;
      checks_done = 0;
      void'($urandom(32'hA649));
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      h.xfer(8, 3);
      repeat (2) @(negedge clk);
      chk(1'b0, oe);
      chk(1'b0, dout);
      for (int t = 0; t < 6; t++) begin
         code = t == 0 ? 12'h000 : t == 1 ? 12'hFFF : 12'($urandom);
         h.xfer(28, 2 + t % 3);
         for (int k = 2; k <= 28; k++) chk(exp_bit(code, k), got[k]);
      end
      end_sim();
   end
endmodule : sadcrs_seq_tb
